// [core/fcs_bus_cycle.v]
// one bus cycle on the flash pins: write or read, strobes framed by the host
// assumes strobes, address and data are launched from flops of this module
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_bus_cycle #(
  parameter AW  = 20,
  parameter PH  = 2
) (
  input  wire          sys_clk,
  input  wire          reset,
  input  wire          go,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire [7:0]    dq_in_sync,
  output reg           done_r,
  output reg  [7:0]    rdata_r,
  output reg           ce_n_r,
  output reg           we_n_r,
  output reg           oe_n_r,
  output reg  [AW-1:0] a_r,
  output reg  [7:0]    dq_out_r,
  output reg           dq_oe_n_r
);
  localparam S_IDLE = 2'd0;
  localparam S_STRB = 2'd1;
  localparam S_HOLD = 2'd2;
  localparam S_GAP  = 2'd3;
  // strobe width of PH+1 cycles, then PH+1 cycles recovery so pipelined reads stay fresh
  localparam CW = 4;
  reg [1:0]    st_r;
  reg [CW-1:0] cnt_r;
  reg          wr_r;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r      <= S_IDLE;
      cnt_r     <= {CW{1'b0}};
      wr_r      <= 1'b0;
      done_r    <= 1'b0;
      rdata_r   <= 8'h00;
      ce_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      a_r       <= {AW{1'b0}};
      dq_out_r  <= 8'h00;
      dq_oe_n_r <= 1'b1;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (go) begin
            // address set up before the strobe falls, captured at that edge
            a_r       <= addr;
            dq_out_r  <= wdata;
            dq_oe_n_r <= ~wr;
            wr_r      <= wr;
            ce_n_r    <= 1'b0;
            st_r      <= S_STRB;
            cnt_r     <= {CW{1'b0}};
          end
        end
        S_STRB: begin
          we_n_r <= ~wr_r;
          oe_n_r <= wr_r;
          cnt_r  <= cnt_r + 1'b1;
          if (cnt_r == PH[CW-1:0]) begin
            st_r  <= S_HOLD;
          end
        end
        S_HOLD: begin
          // data held past the rising strobe edge where the device takes it
          rdata_r <= dq_in_sync;
          we_n_r  <= 1'b1;
          oe_n_r  <= 1'b1;
          st_r    <= S_GAP;
          cnt_r   <= {CW{1'b0}};
        end
        default: begin
          ce_n_r    <= 1'b1;
          dq_oe_n_r <= 1'b1;
          cnt_r     <= cnt_r + 1'b1;
          if (cnt_r == PH[CW-1:0]) begin
            st_r   <= S_IDLE;
            done_r <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// [core/fcs_host.v]
// host controller that issues command sequences to a byte-wide parallel flash
// assumes user orders come from logic on sys_clk; flash pins are asynchronous
// How it works
// - multi-cycle commands issued outside bypass start with AA at 555 then 55 at 2AA
// - F0 written anywhere returns the flash to array reading
// - 90 at 555 after unlocks, then read X00, X01 or X02 with sector
// - program: unlocks, A0 at 555, then byte at target
// - bypass entered with 20 at 555; then A0 and target byte only
// - bypass left with 90 then 00 at any address
// - erase: unlocks, 80, unlocks, then 10 at 555 or 30 at sector
// - after polling bit turns true, take data from a later read
// - after timeout_fail_bit high, re-read polling bit before declaring failure
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_host #(
  parameter AW        = 20,
  parameter PH        = 2,
  parameter POLL_MAX  = 16'hFFFF
) (
  input  wire                sys_clk,
  input  wire                reset,
  input  wire                op_valid,
  input  wire [`FCS_OP_W-1:0] op_code,
  input  wire [AW-1:0]       op_addr,
  input  wire [7:0]          op_data,
  input  wire                poll_en,
  output reg                 op_ready_r,
  output reg                 op_done_r,
  output reg                 op_fail_r,
  output reg  [7:0]          op_rdata_r,
  output reg                 flash_busy_r,
  output wire                ce_n,
  output wire                we_n,
  output wire                oe_n,
  output wire [AW-1:0]       a,
  output wire [7:0]          dq_out,
  output wire                dq_oe_n,
  input  wire [7:0]          dq_in,
  input  wire                ready_busy_out
);
  localparam S_IDLE = 3'd0;
  localparam S_SEQ  = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_POLL = 3'd3;
  localparam S_CHK  = 3'd4;
  localparam S_FIN  = 3'd5;
  localparam SUSP_CYC = `FCS_SUSPEND_NS / `FCS_CLK_NS;
  reg [7:0]    dq_s1_r;
  reg [7:0]    dq_s2_r;
  reg          rb_s1_r;
  reg          rb_s2_r;
  reg [2:0]    st_r;
  reg [2:0]    idx_r;
  reg [2:0]    len_r;
  reg [`FCS_OP_W-1:0] op_r;
  reg [AW-1:0] addr_r;
  reg [7:0]    data_r;
  reg          poll_r;
  reg          tf_seen_r;
  reg [15:0]   pcnt_r;
  reg          go_r;
  reg          wr_r;
  reg [AW-1:0] ca_r;
  reg [7:0]    cd_r;
  wire         cyc_done;
  wire [7:0]   cyc_rdata;
  reg [AW-1:0] step_a;
  reg [7:0]    step_d;
  reg          step_wr;
  // two-flop sync of flash outputs before any use
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_out;
      rb_s2_r <= rb_s1_r;
    end
  end
  function [2:0] seq_len;
    input [`FCS_OP_W-1:0] op;
    begin
      case (op)
        `FCS_OP_READ, `FCS_OP_RESET, `FCS_OP_SUSPEND, `FCS_OP_RESUME: seq_len = 3'd1;
        `FCS_OP_BYP_PROG, `FCS_OP_BYP_EXIT:                         seq_len = 3'd2;
        `FCS_OP_BYP_ENTER:                                          seq_len = 3'd3;
        `FCS_OP_ASEL, `FCS_OP_PROG:                                 seq_len = 3'd4;
        default:                                                    seq_len = 3'd6;
      endcase
    end
  endfunction
  // address and data of step idx for the held order
  always @* begin
    step_wr = 1'b1;
    step_a  = `FCS_ADDR_UNLOCK1;
    step_d  = `FCS_DATA_UNLOCK1;
    if (op_r == `FCS_OP_READ) begin
      step_wr = 1'b0;
      step_a  = addr_r;
    end else if (op_r == `FCS_OP_RESET) begin
      step_d  = `FCS_CMD_RESET;
    end else if (op_r == `FCS_OP_SUSPEND) begin
      step_d  = `FCS_CMD_SUSPEND;
    end else if (op_r == `FCS_OP_RESUME) begin
      step_d  = `FCS_CMD_RESUME;
    end else if (op_r == `FCS_OP_BYP_PROG) begin
      step_d = (idx_r == 3'd0) ? `FCS_CMD_PROGRAM : data_r;
      step_a = (idx_r == 3'd0) ? `FCS_ADDR_ZERO : addr_r;
    end else if (op_r == `FCS_OP_BYP_EXIT) begin
      step_d = (idx_r == 3'd0) ? `FCS_CMD_AUTOSEL : `FCS_CMD_BYP_EXIT2;
      step_a = `FCS_ADDR_ZERO;
    end else if (idx_r == 3'd1 || idx_r == 3'd4) begin
      step_a = `FCS_ADDR_UNLOCK2;
      step_d = `FCS_DATA_UNLOCK2;
    end else if (idx_r == 3'd2) begin
      case (op_r)
        `FCS_OP_ASEL:      step_d = `FCS_CMD_AUTOSEL;
        `FCS_OP_PROG:      step_d = `FCS_CMD_PROGRAM;
        `FCS_OP_BYP_ENTER: step_d = `FCS_CMD_BYPASS;
        default:           step_d = `FCS_CMD_ERASE_SET;
      endcase
    end else if (idx_r == 3'd3 && op_r == `FCS_OP_ASEL) begin
      step_wr = 1'b0;
      step_a  = addr_r;
    end else if (idx_r == 3'd3 && op_r == `FCS_OP_PROG) begin
      step_a = addr_r;
      step_d = data_r;
    end else if (idx_r == 3'd5) begin
      if (op_r == `FCS_OP_SECT_ERASE) begin
        step_a = addr_r;
        step_d = `FCS_CMD_SECT_ERASE;
      end else begin
        step_d = `FCS_CMD_CHIP_ERASE;
      end
    end
  end
  wire is_prog  = (op_r == `FCS_OP_PROG) || (op_r == `FCS_OP_BYP_PROG);
  wire is_erase = (op_r == `FCS_OP_CHIP_ERASE) || (op_r == `FCS_OP_SECT_ERASE);
  // judged on the byte caught inside the read strobe, not the idle bus after it
  wire pol_ok   = is_prog ? (cyc_rdata[`FCS_POLL_BIT] == data_r[`FCS_POLL_BIT])
                          : cyc_rdata[`FCS_POLL_BIT];
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r         <= S_IDLE;
      idx_r        <= 3'd0;
      len_r        <= 3'd1;
      op_r         <= `FCS_OP_READ;
      addr_r       <= {AW{1'b0}};
      data_r       <= 8'h00;
      poll_r       <= 1'b0;
      tf_seen_r    <= 1'b0;
      pcnt_r       <= 16'h0000;
      go_r         <= 1'b0;
      wr_r         <= 1'b0;
      ca_r         <= {AW{1'b0}};
      cd_r         <= 8'h00;
      op_ready_r   <= 1'b0;
      op_done_r    <= 1'b0;
      op_fail_r    <= 1'b0;
      op_rdata_r   <= 8'h00;
      flash_busy_r <= 1'b0;
    end else begin
      go_r         <= 1'b0;
      op_done_r    <= 1'b0;
      flash_busy_r <= ~rb_s2_r;
      case (st_r)
        S_IDLE: begin
          op_ready_r <= 1'b1;
          if (op_valid && op_ready_r) begin
            op_ready_r <= 1'b0;
            op_r       <= op_code;
            addr_r     <= op_addr;
            data_r     <= op_data;
            poll_r     <= poll_en;
            len_r      <= seq_len(op_code);
            idx_r      <= 3'd0;
            op_fail_r  <= 1'b0;
            tf_seen_r  <= 1'b0;
            pcnt_r     <= 16'h0000;
            st_r       <= S_SEQ;
          end
        end
        S_SEQ: begin
          go_r <= 1'b1;
          wr_r <= step_wr;
          ca_r <= step_a;
          cd_r <= step_d;
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            op_rdata_r <= cyc_rdata;
            if (idx_r + 3'd1 < len_r) begin
              idx_r <= idx_r + 3'd1;
              st_r  <= S_SEQ;
            end else if (poll_r && (is_prog || is_erase)) begin
              st_r <= S_POLL;
            end else if (op_r == `FCS_OP_SUSPEND) begin
              pcnt_r <= 16'h0000;
              st_r   <= S_CHK;
            end else begin
              st_r <= S_FIN;
            end
          end
        end
        S_POLL: begin
          go_r <= 1'b1;
          wr_r <= 1'b0;
          ca_r <= addr_r;
          st_r <= S_CHK;
        end
        S_CHK: begin
          if (op_r == `FCS_OP_SUSPEND) begin
            pcnt_r <= pcnt_r + 16'h0001;
            if (pcnt_r == SUSP_CYC[15:0]) begin
              st_r <= S_FIN;
            end
          end else if (cyc_done) begin
            pcnt_r <= pcnt_r + 16'h0001;
            if (pol_ok) begin
              // polling bit may settle before the rest; take a fresh read
              op_r  <= `FCS_OP_READ;
              len_r <= 3'd1;
              idx_r <= 3'd0;
              poll_r <= 1'b0;
              st_r  <= S_SEQ;
            end else if (tf_seen_r || pcnt_r == POLL_MAX) begin
              op_fail_r <= 1'b1;
              op_r  <= `FCS_OP_RESET;
              len_r <= 3'd1;
              idx_r <= 3'd0;
              poll_r <= 1'b0;
              st_r  <= S_SEQ;
            end else begin
              tf_seen_r <= cyc_rdata[`FCS_TFAIL_BIT];
              st_r <= S_POLL;
            end
          end
        end
        default: begin
          op_done_r  <= 1'b1;
          op_ready_r <= 1'b1;
          st_r       <= S_IDLE;
        end
      endcase
    end
  end
  fcs_bus_cycle #(
    .AW (AW),
    .PH (PH)
  ) u_cyc (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .go         (go_r),
    .wr         (wr_r),
    .addr       (ca_r),
    .wdata      (cd_r),
    .dq_in_sync (dq_s2_r),
    .done_r     (cyc_done),
    .rdata_r    (cyc_rdata),
    .ce_n_r     (ce_n),
    .we_n_r     (we_n),
    .oe_n_r     (oe_n),
    .a_r        (a),
    .dq_out_r   (dq_out),
    .dq_oe_n_r  (dq_oe_n)
  );
endmodule

// [core/fcs_regs.vh]
// command codes, addresses and timing constants for the flash command host
// assumes a byte-wide parallel flash with low-active strobes and 20 address bits
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
`define FCS_ADDR_UNLOCK1   20'h00555
`define FCS_ADDR_UNLOCK2   20'h002AA
`define FCS_ADDR_ZERO      20'h00000
`define FCS_DATA_UNLOCK1   8'hAA
`define FCS_DATA_UNLOCK2   8'h55
`define FCS_CMD_RESET      8'hF0
`define FCS_CMD_AUTOSEL    8'h90
`define FCS_CMD_PROGRAM    8'hA0
`define FCS_CMD_BYPASS     8'h20
`define FCS_CMD_BYP_EXIT2  8'h00
`define FCS_CMD_ERASE_SET  8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECT_ERASE 8'h30
`define FCS_CMD_SUSPEND    8'hB0
`define FCS_CMD_RESUME     8'h30
`define FCS_ASEL_MAKER     20'h00000
`define FCS_ASEL_DEVICE    20'h00001
`define FCS_ASEL_PROTECT   20'h00002
`define FCS_SECT_LSB       13
`define FCS_POLL_BIT       7
`define FCS_TFAIL_BIT      5
`define FCS_OP_W           4
`define FCS_OP_READ        4'h0
`define FCS_OP_RESET       4'h1
`define FCS_OP_ASEL        4'h2
`define FCS_OP_PROG        4'h3
`define FCS_OP_BYP_ENTER   4'h4
`define FCS_OP_BYP_PROG    4'h5
`define FCS_OP_BYP_EXIT    4'h6
`define FCS_OP_CHIP_ERASE  4'h7
`define FCS_OP_SECT_ERASE  4'h8
`define FCS_OP_SUSPEND     4'h9
`define FCS_OP_RESUME      4'hA
`define FCS_SUSPEND_NS     20000
`define FCS_CLK_NS         100
`endif

// [tb/fcs_flash_model.sv]
// behavioural byte-wide flash answering the host strobes
// assumes low-active strobes and a pull-up on the rb_n net
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter [7:0] MAKER = 8'h5C, // arbitrary value
  parameter [7:0] DEVID = 8'hC5, // arbitrary value
  parameter [6:0] PS    = 7'h01,
  parameter       P_RD  = 3,
  parameter       E_RD  = 6
) (
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire [19:0] a,
  input  wire [7:0]  wd,
  output reg  [7:0]  rd,
  output wire        rb_n
);
  reg [7:0]  mem [0:2047];
  reg [7:0]  q, pv;
  reg [19:0] la, pa;
  reg [6:0]  es;
  reg [3:0]  n;
  reg        busy, pg, ea, asel, byp, susp, tf, tgl, bad, l5, l2;
  integer    cnt, i;
  initial begin
    for (i = 0; i < 2048; i = i + 1) mem[i] = 8'hFF;
    {n, busy, pg, ea, asel, byp, susp, tf, tgl} = 0;
    rd = 8'h00;
  end
  assign rb_n = busy ? 1'b0 : 1'bz;
  always @* begin
    if (busy) q = {pg & ~pv[7], tgl, tf, 5'h00};
    else if (asel) q = a[1:0] == 2'd0 ? MAKER : a[1:0] == 2'd1 ? DEVID : {7'h00, a[19:13] == PS};
    else if (susp && a[19:13] == es) q = 8'h80;
    else q = mem[{a[19:13], a[3:0]}];
  end
  // released bus shows a changing pattern, not the last byte
  always @(ce_n or oe_n or q) rd = (!ce_n && !oe_n) ? q : ~rd;
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) la = a;
  always @(posedge we_n or posedge ce_n) if (we_n ^ ce_n) wr(wd);
  always @(posedge oe_n) if (!ce_n && busy && !tf) begin
    tgl = ~tgl;
    cnt = cnt - 1;
    if (cnt == 0 && pg && bad) tf = 1'b1;
    else if (cnt == 0) begin
      busy = 1'b0;
      if (pg && pa[19:13] != PS) mem[{pa[19:13], pa[3:0]}] = pv;
      for (i = 0; i < 2048; i = i + 1)
        if (!pg && i[10:4] != PS && (ea || i[10:4] == es)) mem[i] = 8'hFF;
      ea = 1'b0;
    end
  end
  task wr(input [7:0] d);
    begin
      l5 = la[10:0] == 11'h555;
      l2 = la[10:0] == 11'h2AA;
      if (d == 8'hF0 && (!busy || tf)) {n, asel, busy, tf} = 0;
      else if (busy) begin
        if (d == 8'hB0 && !pg && !ea) {busy, susp} = 2'b01;
      end else if (n == 3) begin
        pa = la;
        pv = d;
        bad = |(d & ~mem[{la[19:13], la[3:0]}]);
        {busy, pg, n} = {2'b11, 4'h0};
        cnt = P_RD;
      end else if (byp && n == 0) n = d == 8'hA0 ? 4'd3 : d == 8'h90 ? 4'd5 : 4'd0;
      else if (n == 5) {byp, n} = {d != 8'h00, 4'h0};
      else if (susp && n == 0 && d == 8'h30) begin
        {susp, busy, pg} = 3'b010;
        cnt = E_RD;
      end else case (n)
        0, 6: n = l5 && d == 8'hAA ? n + 1 : 4'd0;
        1, 7: n = l2 && d == 8'h55 ? n + 1 : 4'd0;
        2: begin
          n = !l5 ? 4'd0 : d == 8'hA0 ? 4'd3 : d == 8'h80 ? 4'd6 : 4'd0;
          if (l5) asel = d == 8'h90;
          if (l5 && d == 8'h20) byp = 1'b1;
        end
        8: begin
          n = 0;
          if ((l5 && d == 8'h10) || d == 8'h30) begin
            {es, ea, busy, pg} = {la[19:13], d == 8'h10, 2'b10};
            cnt = E_RD;
          end
        end
        default: n = 0;
      endcase
    end
  endtask
endmodule

// [tb/fcs_props.sv]
// assertions on the flash command host ports
// assumes one clock domain; bound into every fcs_host
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_props #(
  parameter AW = 20
) (
  input wire                 sys_clk,
  input wire                 reset,
  input wire                 op_valid,
  input wire [`FCS_OP_W-1:0] op_code,
  input wire                 op_ready_r,
  input wire                 op_fail_r,
  input wire                 flash_busy_r,
  input wire                 ce_n,
  input wire                 we_n,
  input wire                 oe_n,
  input wire [AW-1:0]        a,
  input wire [7:0]           dq_out,
  input wire                 dq_oe_n,
  input wire                 ready_busy_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire tk = op_valid && op_ready_r;
  wr_frame_a: assert property (!we_n |-> !ce_n && !dq_oe_n && oe_n)
    else $error("write strobe outside a driven select");
  rd_free_a: assert property (!oe_n |-> !ce_n && dq_oe_n && we_n)
    else $error("read while host drives data");
  wr_hold_a: assert property (!we_n && !$past(we_n) |-> $stable(a) && $stable(dq_out))
    else $error("address or data moved during write");
  unlock_a: assert property (tk && op_code == `FCS_OP_PROG |=>
    ##[1:14] ($fell(we_n) && a[10:0] == 11'h555 && dq_out == 8'hAA)
    ##[5:16] ($fell(we_n) && a[10:0] == 11'h2AA && dq_out == 8'h55))
    else $error("unlock pair missing");
  reset_cmd_a: assert property (tk && op_code == `FCS_OP_RESET |=>
    ##[1:14] ($fell(we_n) && dq_out == 8'hF0))
    else $error("reset write missing");
  byp_exit_a: assert property (tk && op_code == `FCS_OP_BYP_EXIT |=>
    ##[1:14] ($fell(we_n) && dq_out == 8'h90) ##[5:16] ($fell(we_n) && dq_out == 8'h00))
    else $error("bypass exit pair missing");
  erase_cmd_a: assert property (tk && op_code == `FCS_OP_SECT_ERASE |=>
    ##[15:60] ($fell(we_n) && a[10:0] == 11'h555 && dq_out == 8'h80))
    else $error("erase setup write missing");
  rb_sync_a: assert property (!ready_busy_out [*4] |-> flash_busy_r)
    else $error("busy line not reported");
  cover property (tk && op_code == `FCS_OP_SUSPEND);
  cover property ($rose(op_fail_r));
  cover property ($rose(flash_busy_r));
endmodule
bind fcs_host fcs_props #(.AW(AW)) fcs_props_i (.sys_clk(sys_clk), .reset(reset),
  .op_valid(op_valid), .op_code(op_code), .op_ready_r(op_ready_r), .op_fail_r(op_fail_r),
  .flash_busy_r(flash_busy_r), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a(a),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ready_busy_out(ready_busy_out));

// [tb/tb_top.sv]
// self-checking bench: host orders against the behavioural flash
// assumes a pulled-up ready line and a 10 MHz clock
`timescale 1ns/1ps
`include "fcs_regs.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_top;
  reg         sys_clk = 1'b0;
  reg         reset = 1'b1;
  reg         op_valid = 1'b0;
  reg  [3:0]  op_code = 4'h0;
  reg  [19:0] op_addr = 20'h00000;
  reg  [7:0]  op_data = 8'h00;
  reg         poll_en = 1'b0;
  reg         sb;
  integer     fail_count = 0;
  integer     samples_checked = 0;
  wire        op_ready_r, op_done_r, op_fail_r, flash_busy_r, ce_n, we_n, oe_n, dq_oe_n;
  wire [7:0]  op_rdata_r, dq_out, frd;
  wire [19:0] a;
  tri1        rb;
  wire [7:0]  dq_in = dq_oe_n ? frd : dq_out;
  fcs_host #(.POLL_MAX(16'h0040)) fcs_host_i (.sys_clk(sys_clk), .reset(reset),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_data(op_data),
    .poll_en(poll_en), .op_ready_r(op_ready_r), .op_done_r(op_done_r), .op_fail_r(op_fail_r),
    .op_rdata_r(op_rdata_r), .flash_busy_r(flash_busy_r), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .a(a), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
    .ready_busy_out(rb));
  fcs_flash_model fcs_flash_model_i (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a(a),
    .wd(dq_out), .rd(frd), .rb_n(rb));
  always #50 sys_clk = ~sys_clk;
  task op(input [3:0] c, input [19:0] ad, input [7:0] d, input p);
    integer k;
    begin
      {sb, k, op_code, op_addr, op_data, poll_en, op_valid} = {1'b0, 32'd0, c, ad, d, p, 1'b1};
      while (op_ready_r !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk) op_valid = 1'b0;
      while (op_done_r !== 1'b1 && k < 3000) begin
        @(negedge sys_clk);
        sb = sb | flash_busy_r;
        k = k + 1;
      end
      `CHK("op done", 1'b1, op_done_r)
      @(negedge sys_clk);
    end
  endtask
  task rd_chk(input [19:0] ad, input [7:0] e);
    begin
      op(`FCS_OP_READ, ad, 8'h00, 1'b0);
      `CHK("array byte", e, op_rdata_r)
    end
  endtask
  task s_prog;
    begin
      rd_chk(20'h04003, 8'hFF);
      op(`FCS_OP_PROG, 20'h04003, 8'h5A, 1'b1);
      `CHK("prog fail", 1'b0, op_fail_r)
      `CHK("prog busy", 1'b1, sb)
      `CHK("poll data", 8'h5A, op_rdata_r)
      rd_chk(20'h04003, 8'h5A);
    end
  endtask
  task s_asel;
    begin
      op(`FCS_OP_ASEL, `FCS_ASEL_MAKER, 8'h00, 1'b0);
      `CHK("maker", fcs_flash_model_i.MAKER, op_rdata_r)
      op(`FCS_OP_ASEL, `FCS_ASEL_DEVICE, 8'h00, 1'b0);
      `CHK("device", fcs_flash_model_i.DEVID, op_rdata_r)
      op(`FCS_OP_ASEL, 20'h02002, 8'h00, 1'b0);
      `CHK("protected", 8'h01, op_rdata_r)
      op(`FCS_OP_ASEL, 20'h04002, 8'h00, 1'b0);
      `CHK("unprotected", 8'h00, op_rdata_r)
      op(`FCS_OP_RESET, 20'h00000, 8'h00, 1'b0);
      rd_chk(20'h04003, 8'h5A);
    end
  endtask
  task s_prot;
    begin
      op(`FCS_OP_PROG, 20'h02005, 8'h80, 1'b1);
      `CHK("prot prog", 1'b0, op_fail_r)
      rd_chk(20'h02005, 8'hFF);
      op(`FCS_OP_SECT_ERASE, 20'h02000, 8'h00, 1'b1);
      `CHK("prot erase", 1'b0, op_fail_r)
    end
  endtask
  task s_fail;
    begin
      op(`FCS_OP_PROG, 20'h04003, 8'hFF, 1'b1);
      `CHK("timeout", 1'b1, op_fail_r)
      rd_chk(20'h04003, 8'h5A);
    end
  endtask
  task s_byp;
    begin
      op(`FCS_OP_BYP_ENTER, 20'h00000, 8'h00, 1'b0);
      op(`FCS_OP_BYP_PROG, 20'h06001, 8'h33, 1'b1);
      `CHK("bypass prog", 8'h33, op_rdata_r)
      op(`FCS_OP_BYP_EXIT, 20'h00000, 8'h00, 1'b0);
      op(`FCS_OP_ASEL, `FCS_ASEL_MAKER, 8'h00, 1'b0);
      `CHK("after exit", fcs_flash_model_i.MAKER, op_rdata_r)
      op(`FCS_OP_RESET, 20'h00000, 8'h00, 1'b0);
    end
  endtask
  task s_susp;
    begin
      op(`FCS_OP_PROG, 20'h08001, 8'h11, 1'b1);
      op(`FCS_OP_SECT_ERASE, 20'h08000, 8'h00, 1'b0);
      `CHK("erasing", 1'b1, flash_busy_r)
      op(`FCS_OP_SUSPEND, 20'h00000, 8'h00, 1'b0);
      `CHK("suspended", 1'b0, flash_busy_r)
      op(`FCS_OP_READ, 20'h08001, 8'h00, 1'b0);
      `CHK("susp poll", 1'b1, op_rdata_r[7])
      op(`FCS_OP_PROG, 20'h0A002, 8'h22, 1'b1);
      `CHK("susp prog", 8'h22, op_rdata_r)
      op(`FCS_OP_RESUME, 20'h08000, 8'h00, 1'b0);
      `CHK("resume", 1'b0, op_fail_r)
      `CHK("resumed busy", 1'b1, flash_busy_r)
      op(`FCS_OP_READ, 20'h08000, 8'h00, 1'b0);
      `CHK("erase poll", 1'b0, op_rdata_r[7])
      // resume is not polled by the host; status reads carry the erase to its end
      repeat (fcs_flash_model_i.E_RD - 1) op(`FCS_OP_READ, 20'h08000, 8'h00, 1'b0);
      rd_chk(20'h08001, 8'hFF);
      op(`FCS_OP_CHIP_ERASE, 20'h0A000, 8'h00, 1'b1);
      rd_chk(20'h0A002, 8'hFF);
    end
  endtask
  task end_of_test;
    begin
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    s_prog;
    s_asel;
    s_prot;
    s_fail;
    s_byp;
    s_susp;
    end_of_test;
  end
  initial begin
    #5000000;
    fail_count = fail_count + 1;
    end_of_test;
  end
endmodule
